//--- shared/cmm_pkg.sv
`default_nettype none
package cmm_pkg;
    // channel and unit layout
    localparam int NUM_CH      = 4;
    localparam int CH_PER_UNIT = 2;
    localparam int NUM_UNIT    = 2;
    localparam int CNT_W       = 16;
    localparam int PRE_W       = 9;
    localparam int ADDR_W      = 8;
    // per-channel window: channel in addr[5:4], register in addr[3:2]
    localparam logic [1:0] REG_CTRL  = 2'h0;
    localparam logic [1:0] REG_CONST = 2'h1;
    localparam logic [1:0] REG_COUNT = 2'h2;
    localparam logic [1:0] REG_STAT  = 2'h3;
    // global registers
    localparam logic [7:0] OFS_UNIT_STOP  = 8'h40;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h44;
    localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h48;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h4c;
    localparam logic [7:0] OFS_LAST       = 8'h4c;
    // prescaler terminal counts for /8, /32, /128, /512
    localparam logic [8:0] PRE_LAST_8   = 9'h007;
    localparam logic [8:0] PRE_LAST_32  = 9'h01f;
    localparam logic [8:0] PRE_LAST_128 = 9'h07f;
    localparam logic [8:0] PRE_LAST_512 = 9'h1ff;
    // reset values
    localparam logic [15:0] CONST_RESET = 16'hffff;
    localparam logic [1:0]  STOP_RESET  = 2'h0;
    localparam logic [3:0]  IEN_RESET   = 4'h0;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {DIV_8, DIV_32, DIV_128, DIV_512} cmm_div_t;
    typedef enum logic [1:0] {TRIG_NONE, TRIG_DMA, TRIG_DTC, TRIG_RSVD} cmm_trig_t;

    // control word: start bit 0, one-shot bit 1, divider 3:2, trigger 5:4
    typedef struct packed {
        cmm_trig_t trig;
        cmm_div_t  div;
        logic      oneShot;
        logic      start;
    } cmm_chcfg_t;
    localparam cmm_chcfg_t CFG_RESET = '0;

    // last prescaler count for a divider choice
    function automatic logic [8:0] cmm_pre_last(input cmm_div_t d);
        case (d)
            DIV_8:   return PRE_LAST_8;
            DIV_32:  return PRE_LAST_32;
            DIV_128: return PRE_LAST_128;
            default: return PRE_LAST_512;
        endcase
    endfunction

    // byte-strobe merge of a write into an old word
    function automatic logic [31:0] cmm_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction
endpackage
`default_nettype wire

//--- design/cmm_channel.sv
`timescale 1ns/10ps
`default_nettype none
module cmm_channel
    import cmm_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          run,       // start set and unit not stopped
    input  wire cmm_div_t      div,       // divider choice
    input  wire logic [CW-1:0] compare,   // compare constant
    input  wire logic          cntWrEn,   // software write of the count
    input  wire logic [CW-1:0] cntWrData, // value written
    output logic      [CW-1:0] count,     // live count value
    output logic               match      // one-cycle match pulse
);
    logic [PRE_W-1:0] preCount;   // prescaler of the bus clock
    logic [CW-1:0]    next_count; // count after this edge
    wire              tick;       // one divided count clock
    wire              hit;        // count equals constant on a tick

    // prescaler wraps at the selected terminal count
    assign tick = run && (preCount == cmm_pre_last(div));
    assign hit  = tick && (count == compare);

    // prescaler is held at zero while stopped
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) preCount <= '0;
        else if (!run || tick) preCount <= '0;
        else preCount <= preCount + 9'h001;
    end

    // write equal to the constant lands as zero match clears
    always_comb begin
        next_count = count;
        if (cntWrEn) next_count = (cntWrData == compare) ? '0 : cntWrData;
        else if (hit) next_count = '0;
        else if (tick) next_count = count + 16'h0001;
    end

    // count and match pulse registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
            match <= 1'b0;
        end else begin
            count <= next_count;
            match <= hit && !cntWrEn;
        end
    end

    a_match_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        hit && !cntWrEn |=> count == '0 && match)
        else $error("count did not clear on match");
    a_stop_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !run && !cntWrEn |=> $stable(count))
        else $error("count moved while stopped");
    a_write_equal: assert property (@(posedge sys_clk) disable iff (!rstn)
        cntWrEn && cntWrData == compare |=> count == '0)
        else $error("equal write did not give zero");
    a_tick_space: assert property (@(posedge sys_clk) disable iff (!rstn)
        tick |=> !tick [*7])
        else $error("count clocks closer than eight cycles");
    c_match_seen: cover property (@(posedge sys_clk) disable iff (!rstn) match);
endmodule
`default_nettype wire

//--- design/cmm_top.sv
`timescale 1ns/10ps
`default_nettype none
module cmm_top
    import cmm_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   irq,
    output logic [NUM_CH-1:0]      dmaReq,
    output logic [NUM_CH-1:0]      dtcReq
);
    // software-visible state and per-channel internal strobes
    cmm_chcfg_t          cfg      [NUM_CH]; // control words
    logic [CNT_W-1:0]    compare  [NUM_CH]; // compare constants
    logic [CNT_W-1:0]    chCount  [NUM_CH]; // live counts
    logic [NUM_UNIT-1:0] unitStop;          // module stop per unit
    logic [NUM_CH-1:0]   matchFlag;         // clear-on-read match flags
    logic [NUM_CH-1:0]   irqStatus;         // sticky interrupt status
    logic [NUM_CH-1:0]   irqEnable;         // interrupt enables
    logic [NUM_CH-1:0]   matchEv;           // match pulses from channels
    logic [NUM_CH-1:0]   cntWrEn;           // count write strobes
    logic [NUM_CH-1:0]   chRun;             // channel is counting

    // write channel holding registers
    logic [ADDR_W-1:0] awAddr;   // captured write address
    logic              awHeld;   // address captured
    logic [31:0]       wData;    // captured write data
    logic [3:0]        wStrb;    // captured strobes
    logic              wHeld;    // data captured

    // write decode
    wire              doWrite = awHeld && wHeld && !s_axi_bvalid;
    wire              wIsCh   = (awAddr[7:6] == 2'h0);
    wire [1:0]        wCh     = awAddr[5:4];
    wire [1:0]        wReg    = awAddr[3:2];
    wire              wOk     = wIsCh || (awAddr <= OFS_LAST);
    wire              wStop   = doWrite && (awAddr == OFS_UNIT_STOP);
    wire              wIclr   = doWrite && (awAddr == OFS_IRQ_CLEAR);
    wire              wIen    = doWrite && (awAddr == OFS_IRQ_ENABLE);
    wire [31:0]       wMasked = cmm_merge(32'h0000_0000, wData, wStrb);

    // read decode
    wire              arTake  = s_axi_arvalid && s_axi_arready;
    wire              rIsCh   = (s_axi_araddr[7:6] == 2'h0);
    wire [1:0]        rCh     = s_axi_araddr[5:4];
    wire [1:0]        rReg    = s_axi_araddr[3:2];
    wire              rOk     = rIsCh || (s_axi_araddr <= OFS_LAST);
    wire [31:0]       rChWord = (rReg == REG_CTRL)  ? {26'h0, cfg[rCh]} :
                                (rReg == REG_CONST) ? {16'h0, compare[rCh]} :
                                (rReg == REG_COUNT) ? {16'h0, chCount[rCh]} :
                                                      {31'h0, matchFlag[rCh]};
    wire [31:0]       rGlob   = (s_axi_araddr == OFS_UNIT_STOP)  ? {30'h0, unitStop} :
                                (s_axi_araddr == OFS_IRQ_STATUS) ? {28'h0, irqStatus} :
                                (s_axi_araddr == OFS_IRQ_ENABLE) ? {28'h0, irqEnable} :
                                                                   32'h0000_0000;
    wire [31:0]       rWord   = !rOk ? 32'h0000_0000 : (rIsCh ? rChWord : rGlob);
    wire              rStat   = arTake && rIsCh && (rReg == REG_STAT);
    wire [NUM_CH-1:0] rdClr   = rStat ? (4'h1 << rCh) : 4'h0;

    // handshake outputs
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // interrupt is a level of enabled sticky bits
    assign irq = |(irqStatus & irqEnable);

    // one channel per index, run gated by its unit's stop
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            assign chRun[gi]   = cfg[gi].start && !unitStop[gi / CH_PER_UNIT];
            assign cntWrEn[gi] = doWrite && wIsCh && (wCh == gi) && (wReg == REG_COUNT);
            cmm_channel #(
                .CW(CNT_W)
            ) u_ch (
                .sys_clk   (sys_clk),
                .rstn      (rstn),
                .run       (chRun[gi]),
                .div       (cfg[gi].div),
                .compare   (compare[gi]),
                .cntWrEn   (cntWrEn[gi]),
                .cntWrData (wData[CNT_W-1:0]),
                .count     (chCount[gi]),
                .match     (matchEv[gi])
            );
        end
    endgenerate

    // capture write address and data in either order
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awAddr <= '0;
            wData  <= '0;
            wStrb  <= '0;
        end else if (doWrite) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read data registered one cycle after the address
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rWord;
            s_axi_rresp  <= rOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control words and constants; one-shot self-stop wins over writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cfg[i]     <= CFG_RESET;
                compare[i] <= CONST_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (doWrite && wIsCh && wCh == i && wReg == REG_CTRL)
                    cfg[i] <= cmm_chcfg_t'(6'(cmm_merge({26'h0, cfg[i]}, wData, wStrb)));
                if (doWrite && wIsCh && wCh == i && wReg == REG_CONST)
                    compare[i] <= CNT_W'(cmm_merge({16'h0, compare[i]}, wData, wStrb));
                if (matchEv[i] && cfg[i].oneShot)
                    cfg[i].start <= 1'b0;
            end
        end
    end

    // unit stop and interrupt enable registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            unitStop  <= STOP_RESET;
            irqEnable <= IEN_RESET;
        end else begin
            if (wStop) unitStop <= NUM_UNIT'(cmm_merge({30'h0, unitStop}, wData, wStrb));
            if (wIen) irqEnable <= NUM_CH'(cmm_merge({28'h0, irqEnable}, wData, wStrb));
        end
    end

    // sticky flags: a match in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            matchFlag <= '0;
            irqStatus <= '0;
        end else begin
            matchFlag <= (matchFlag & ~rdClr) | matchEv;
            irqStatus <= (irqStatus & ~(wIclr ? wMasked[NUM_CH-1:0] : 4'h0)) | matchEv;
        end
    end

    // transfer-controller activation pulses per trigger choice
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dmaReq <= '0;
            dtcReq <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                dmaReq[i] <= matchEv[i] && (cfg[i].trig == TRIG_DMA);
                dtcReq[i] <= matchEv[i] && (cfg[i].trig == TRIG_DTC);
            end
        end
    end

    a_oneshot_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
        matchEv[0] && cfg[0].oneShot |=> !cfg[0].start ##1 !matchEv[0] [*8])
        else $error("one-shot channel kept running");
    a_irq_raise: assert property (@(posedge sys_clk) disable iff (!rstn)
        matchEv[2] && irqEnable[2] && !wIen |=> irq)
        else $error("enabled match gave no interrupt");
    a_dma_route: assert property (@(posedge sys_clk) disable iff (!rstn)
        matchEv[0] && cfg[0].trig == TRIG_DMA |=> dmaReq[0] && !dtcReq[0])
        else $error("dma request missing on match");
    a_dtc_route: assert property (@(posedge sys_clk) disable iff (!rstn)
        !matchEv[3] |=> !dtcReq[3] && !dmaReq[3])
        else $error("transfer request without match");
    a_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        matchEv[0] |=> matchFlag[0] && irqStatus[0])
        else $error("match flag not set");
    a_unit_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
        unitStop[1] && !cntWrEn[2] && !cntWrEn[3] |=> $stable(chCount[2]) && $stable(chCount[3]))
        else $error("stopped unit kept counting");
    a_write_resp: assert property (@(posedge sys_clk) disable iff (!rstn)
        doWrite |=> s_axi_bvalid)
        else $error("write answer late");

    c_oneshot: cover property (@(posedge sys_clk) disable iff (!rstn) matchEv[0] && cfg[0].oneShot);
    c_irq: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(irq));
    c_dma: cover property (@(posedge sys_clk) disable iff (!rstn) dmaReq[0]);
    c_stop: cover property (@(posedge sys_clk) disable iff (!rstn) unitStop[1] && cfg[2].start);
endmodule
`default_nettype wire

//--- sim/cmm_req_sink.sv
`timescale 1ns/10ps
`default_nettype none
module cmm_req_sink
    import cmm_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic [NUM_CH-1:0] dmaReq,
    input wire logic [NUM_CH-1:0] dtcReq
);
    int cyc;              // cycles since reset
    int dmaCnt  [NUM_CH]; // dma activations taken
    int dtcCnt  [NUM_CH]; // transfer activations taken
    int dmaGap  [NUM_CH]; // cycles between last two dma pulses
    int dtcGap  [NUM_CH]; // cycles between last two transfer pulses
    int dmaLast [NUM_CH]; // cycle of last dma pulse
    int dtcLast [NUM_CH]; // cycle of last transfer pulse

    // take every one-cycle request and time it against the one before
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cyc = 0;
            for (int c = 0; c < NUM_CH; c++) begin
                dmaCnt[c] = 0;
                dtcCnt[c] = 0;
                dmaLast[c] = 0;
                dtcLast[c] = 0;
            end
        end else begin
            cyc++;
            for (int c = 0; c < NUM_CH; c++) begin
                // dma controller side
                if (dmaReq[c] === 1'h1) begin
                    dmaCnt[c]++;
                    dmaGap[c] = cyc - dmaLast[c];
                    dmaLast[c] = cyc;
                end
                // transfer controller side
                if (dtcReq[c] === 1'h1) begin
                    dtcCnt[c]++;
                    dtcGap[c] = cyc - dtcLast[c];
                    dtcLast[c] = cyc;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/compare_match_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module compare_match_timer_test
    import cmm_pkg::*;
;
    logic              sys_clk = 1'h0;
    logic              rstn = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
    logic [NUM_CH-1:0] dmaReq, dtcReq;
    logic [31:0]       rd, c1, c2;   // read word and kept counts
    logic [1:0]        trg [NUM_CH] = '{2'h1, 2'h2, 2'h0, 2'h3}; // trigger per channel
    int                failures = 0, checked = 0, cycles = 0, n0;

    // 100 MHz bus clock
    always #5 sys_clk = ~sys_clk;

    cmm_top dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
                 .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
                 .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
                 .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .dmaReq, .dtcReq);
    cmm_req_sink sink (.sys_clk, .rstn, .dmaReq, .dtcReq);

    // verdict and end of run
    task automatic close_out;
        if (failures == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // one comparison
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    // channel register address
    function automatic logic [7:0] ra(input logic [1:0] ch, input logic [1:0] r);
        return {2'h0, ch, r, 2'h0};
    endfunction

    // control word
    function automatic logic [31:0] ctl(input logic [1:0] t, input logic [1:0] d, input logic os,
                                        input logic st);
        return {26'h0, t, d, os, st};
    endfunction

    // bus write: both halves offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask

    // bus read
    task automatic axr(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask

    // read and compare
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        check(what, rd, exp);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'h1;
        for (int c = 0; c < NUM_CH; c++) begin
            rc("ctrl", ra(2'(c), REG_CTRL), 32'h0);
            rc("const", ra(2'(c), REG_CONST), {16'h0, CONST_RESET});
            rc("count", ra(2'(c), REG_COUNT), 32'h0);
        end
        rc("unitstop", OFS_UNIT_STOP, 32'h0);
        rc("irqen", OFS_IRQ_ENABLE, 32'h0);
        rc("unmapped", 8'h50, 32'h0);
        check("rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        axw(8'h50, 32'h1);
        check("bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        // each divider and each trigger code once, shortest period on channel 0
        axw(ra(2'h0, REG_CONST), 32'h0);
        for (int c = 1; c < NUM_CH; c++) axw(ra(2'(c), REG_CONST), 32'h1);
        axw(OFS_IRQ_ENABLE, 32'h4);
        check("bresp ok", {30'h0, rsp}, {30'h0, RESP_OKAY});
        for (int c = 0; c < NUM_CH; c++) axw(ra(2'(c), REG_CTRL), ctl(trg[c], 2'(c), 1'h0, 1'h1));
        repeat (2200) @(posedge sys_clk);
        check("gap0", sink.dmaGap[0], 32'h8);
        check("gap1", sink.dtcGap[1], 32'h40);
        check("stray", sink.dtcCnt[0] + sink.dmaCnt[1] + sink.dmaCnt[2] + sink.dtcCnt[2]
                       + sink.dmaCnt[3] + sink.dtcCnt[3], 32'h0);
        check("irq", {31'h0, irq}, 32'h1);
        rc("status", OFS_IRQ_STATUS, 32'hf);
        rc("stat3", ra(2'h3, REG_STAT), 32'h1);
        axw(OFS_IRQ_ENABLE, 32'h0);
        check("masked", {31'h0, irq}, 32'h0);
        for (int c = 0; c < NUM_CH; c++) axw(ra(2'(c), REG_CTRL), ctl(trg[c], 2'(c), 1'h0, 1'h0));
        axw(OFS_IRQ_CLEAR, 32'hf);
        rc("cleared", OFS_IRQ_STATUS, 32'h0);
        rc("stat1", ra(2'h1, REG_STAT), 32'h1);
        rc("stat1again", ra(2'h1, REG_STAT), 32'h0);
        // unit one stop freezes channel 2
        axw(ra(2'h2, REG_CONST), 32'h100);
        axw(ra(2'h2, REG_CTRL), ctl(2'h0, 2'h0, 1'h0, 1'h1));
        repeat (100) @(posedge sys_clk);
        axr(ra(2'h2, REG_COUNT));
        c1 = rd;
        repeat (20) @(posedge sys_clk);
        axr(ra(2'h2, REG_COUNT));
        check("ran", {31'h0, rd != c1}, 32'h1);
        axw(OFS_UNIT_STOP, 32'h2);
        axr(ra(2'h2, REG_COUNT));
        c2 = rd;
        repeat (100) @(posedge sys_clk);
        rc("held", ra(2'h2, REG_COUNT), c2);
        axw(OFS_UNIT_STOP, 32'h0);
        repeat (50) @(posedge sys_clk);
        axr(ra(2'h2, REG_COUNT));
        check("resumed", {31'h0, rd != c2}, 32'h1);
        // start bit cleared holds the count
        axw(ra(2'h2, REG_CTRL), ctl(2'h0, 2'h0, 1'h0, 1'h0));
        axr(ra(2'h2, REG_COUNT));
        c2 = rd;
        repeat (50) @(posedge sys_clk);
        rc("hold", ra(2'h2, REG_COUNT), c2);
        axw(ra(2'h2, REG_COUNT), 32'h100);
        rc("loadeq", ra(2'h2, REG_COUNT), 32'h0);
        axw(ra(2'h2, REG_COUNT), 32'h7);
        rc("load", ra(2'h2, REG_COUNT), 32'h7);
        // one-shot on channel 0 with dma trigger
        axw(ra(2'h0, REG_CONST), 32'h5);
        n0 = sink.dmaCnt[0];
        axw(ra(2'h0, REG_CTRL), ctl(2'h1, 2'h0, 1'h1, 1'h1));
        repeat (200) @(posedge sys_clk);
        check("oneshot", sink.dmaCnt[0] - n0, 32'h1);
        rc("selfstop", ra(2'h0, REG_CTRL), ctl(2'h1, 2'h0, 1'h1, 1'h0));
        rc("rest", ra(2'h0, REG_COUNT), 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
